// File: hdl/dop_gain_latch.sv
/*
 One channel of the external amplifier gain port: holds the gain word
 and pulses an active-low latch strobe after each update.
 Assumes hold_in is high during reset or sync; strobe then stays low.
*/
`timescale 1ns/100ps
module dop_gain_latch
   import dop_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic       hold_in,
   input  wire logic       update_in,
   input  wire logic [2:0] gain_in,
   output logic      [2:0] gain_word_out,
   output logic            gain_latch_n_out
);

   logic [1:0] cnt_q;

   // ==========================================================
   // Word captured on update, strobe counted out afterwards
   always_ff @(posedge clk_in) begin
      if (hold_in) begin
         gain_word_out <= 3'h0;
         cnt_q         <= 2'h0;
      end else if (update_in) begin
         gain_word_out <= gain_in;
         cnt_q         <= DOP_STROBE_CYC;
      end else if (cnt_q != 2'h0) begin
         cnt_q <= cnt_q - 2'h1;
      end
   end

   // Low while held, so the amplifier starts from a known word
   assign gain_latch_n_out = ~(hold_in | (cnt_q != 2'h0));

endmodule

// File: hdl/dop_pkg.sv
/*
 Shared constants and carrier types for the downconverter output port:
 register offsets, control fields, reset values, counts and pin bundles.
 Assumes a single 25 MHz clock and an APB register bus with 8-bit addresses.
*/
package dop_pkg;

   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [7:0]  DOP_CTRL_OFS    = 8'h00;
   localparam logic [7:0]  DOP_DEBUG_OFS   = 8'h04;
   localparam logic [7:0]  DOP_IRQ_ST_OFS  = 8'h08;
   localparam logic [7:0]  DOP_IRQ_MSK_OFS = 8'h0C;
   localparam logic [7:0]  DOP_STATE_OFS   = 8'h10;
   localparam logic [7:0]  DOP_DAISY_OFS   = 8'h14;

   // ==========================================================
   // Control register fields
   localparam int          DOP_C_SER_EN    = 0;
   localparam int          DOP_C_BCK_POL   = 1;
   localparam int          DOP_C_PACKED    = 2;
   localparam int          DOP_C_FRM_POL   = 3;
   localparam int          DOP_C_RDY_POL   = 4;
   localparam int          DOP_C_DEBUG     = 5;
   localparam int          DOP_C_MASTER    = 6;
   localparam int          DOP_C_SLV_POL   = 7;
   localparam int          DOP_C_RATE_LO   = 8;
   localparam int          DOP_C_RATE_HI   = 15;

   // ==========================================================
   // Reset values
   localparam logic [15:0] DOP_CTRL_RST    = 16'h0000;
   localparam logic [19:0] DOP_DEBUG_RST   = 20'h00000;
   localparam logic [1:0]  DOP_IRQ_RST     = 2'h0;
   localparam logic [1:0]  DOP_CONV_RST    = 2'h0;
   // Pin order {drive_n, select[2:0], bit clock, sync_n, reset_n, power down}
   localparam logic [7:0]  DOP_PIN_INIT    = 8'h86;

   // ==========================================================
   // Counts
   localparam logic [4:0]  DOP_FRAME_LAST  = 5'h1F;
   localparam logic [4:0]  DOP_HALF_WORD   = 5'h10;
   localparam logic [4:0]  DOP_DAISY_LAST  = 5'h0F;
   localparam logic [1:0]  DOP_STROBE_CYC  = 2'h2;

   // ==========================================================
   // Carrier types
   typedef struct packed {
      logic        valid;
      logic [15:0] a_i;
      logic [15:0] a_q;
      logic [15:0] b_i;
      logic [15:0] b_q;
   } dop_sample_type;

   typedef struct packed {
      logic       a_update;
      logic       b_update;
      logic [2:0] a_gain;
      logic [2:0] b_gain;
   } dop_agc_type;

   typedef struct packed {
      logic chan_a_serial_data;
      logic chan_b_serial_data;
      logic serial_frame_pulse;
      logic bit_clock;
   } dop_serial_type;

   typedef enum logic [1:0] {
      DOP_IDLE  = 2'b01,
      DOP_SHIFT = 2'b10
   } dop_state_type;

endpackage

// File: hdl/dop_sync.sv
/*
 Two flip-flop synchroniser for a group of pin levels.
 Assumes each bit is an independent slow level; no word coherency.
*/
`timescale 1ns/100ps
module dop_sync #(
   parameter int         WIDTH = 8,
   parameter logic [7:0] INIT  = 8'h00
) (
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   input  wire logic [WIDTH-1:0] pins_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;

   // ==========================================================
   // First stage feeds only the second stage
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         meta_q   <= INIT[WIDTH-1:0];
         sync_out <= INIT[WIDTH-1:0];
      end else begin
         meta_q   <= pins_in;
         sync_out <= meta_q;
      end
   end

endmodule

// File: hdl/dop_top.sv
/*
 Output side of a dual channel downconverter: serial and parallel sample
 ports, daisy-chain capture, ready flag, debug remap, gain ports, pins.
 Assumes samples and gain updates come from same-clock logic and all pins
 come from outside the clock domain. Registers are reached over APB.
*/
// What this block does
// - Power-down pin high disables both converters, low enables them.
// - Master reset low clears all registers but the pin synchronisers and holds both gain strobes low.
// - Serial data is two's complement, most significant bit first.
// - Data changes on bit clock rising edge; polarity bit swaps both edges.
// - Serial pins undriven after power-up until serial enable bit is set.
// - Debug mode maps debug bits 1, 0, 2 onto A, B, frame; clock keeps running.
// - Rate zero makes the bit clock follow the input clock directly.
// - Daisy master captures slave bits on falling clock edge, rising if inverted.
// - Frame pulse starts each word, or each I/Q pair when packed; polarity set.
// - Word select picks one of eight words; bit 15 is most significant.
// - Parallel bus driven only while enable low; enable ignored in debug.
// - Debug mode shows debug bits 19 to 4 on the parallel bus.
// - Daisy master reads select pins as slave frame, B data, A data.
// - Ready flag marks each output sample period start, polarity set.
// - Ready flag always driven; debug mode puts debug bit 3 on it.
// - Each channel drives a 3-bit gain word from gain control logic.
// - Each channel pulses an active-low strobe latching the gain word.
// - Sync pin is registered and holds both gain strobes low while active.
`timescale 1ns/100ps
module dop_top
   import dop_pkg::*;
(
   input  wire logic           clk_in,
   input  wire logic           rst_in,
   input  wire logic           psel_in,
   input  wire logic           penable_in,
   input  wire logic           pwrite_in,
   input  wire logic [7:0]     paddr_in,
   input  wire logic [31:0]    pwdata_in,
   output logic      [31:0]    prdata_out,
   output logic                pready_out,
   output logic                pslverr_out,
   input  wire dop_sample_type sample_in,
   input  wire dop_agc_type    agc_in,
   input  wire logic           converter_power_down_in,
   input  wire logic           master_reset_n_in,
   input  wire logic           sync_n_in,
   input  wire logic           daisy_bit_clock_in,
   input  wire logic [2:0]     parallel_word_select_in,
   input  wire logic           parallel_drive_enable_n_in,
   output logic      [1:0]     converter_enable_out,
   output dop_serial_type      serial_pins_out,
   output logic                serial_oe_out,
   output logic      [15:0]    parallel_word_bus_out,
   output logic                parallel_oe_out,
   output logic                ready_flag_out,
   output logic      [2:0]     chan_a_gain_word_out,
   output logic      [2:0]     chan_b_gain_word_out,
   output logic                chan_a_gain_latch_n_out,
   output logic                chan_b_gain_latch_n_out,
   output logic                irq_out
);

   // ==========================================================
   // Pin synchronisers
   logic [7:0] pins_s;
   wire  logic pdn_s   = pins_s[0];
   wire  logic mrn_s   = pins_s[1];
   wire  logic sync_n_s = pins_s[2];
   wire  logic sck_s   = pins_s[3];
   wire  logic [2:0] sel_s = pins_s[6:4];
   wire  logic pen_n_s = pins_s[7];

   dop_sync #(
      .WIDTH (8),
      .INIT  (DOP_PIN_INIT)
   ) u_pins (
      .clk_in   (clk_in),
      .rst_in   (rst_in),
      .pins_in  ({parallel_drive_enable_n_in, parallel_word_select_in,
                  daisy_bit_clock_in, sync_n_in, master_reset_n_in,
                  converter_power_down_in}),
      .sync_out (pins_s)
   );

   // Master reset pin joins the system reset for every register but the pin synchronisers
   wire logic core_rst = rst_in | ~mrn_s;
   wire logic sync_act = ~sync_n_s;
   // Sync flushes sample data in flight as well
   wire logic ser_rst  = core_rst | sync_act;

   // ==========================================================
   // Registers
   logic [15:0]    ctrl_q;
   logic [19:0]    dbg_q;
   logic [1:0]     irq_st_q;
   logic [1:0]     irq_msk_q;
   logic [1:0]     conv_en_q;
   dop_sample_type samp_q;
   logic           pend_q;
   dop_state_type  state_q;
   logic [4:0]     bit_cnt_q;
   logic [31:0]    sh_a_q;
   logic [31:0]    sh_b_q;
   logic [7:0]     div_cnt_q;
   logic           phase_q;
   logic           rdy_q;
   logic           sck_prev_q;
   logic [4:0]     dsy_cnt_q;
   logic [15:0]    dsy_a_q;
   logic [15:0]    dsy_b_q;
   logic [15:0]    cap_a_q;
   logic [15:0]    cap_b_q;
   logic           dsy_done_q;
   logic [15:0]    par_q;
   logic [31:0]    rdata_q;

   // Control fields
   wire logic       ser_en   = ctrl_q[DOP_C_SER_EN];
   wire logic       bck_pol  = ctrl_q[DOP_C_BCK_POL];
   wire logic       packed_m = ctrl_q[DOP_C_PACKED];
   wire logic       frm_pol  = ctrl_q[DOP_C_FRM_POL];
   wire logic       rdy_pol  = ctrl_q[DOP_C_RDY_POL];
   wire logic       debug_m  = ctrl_q[DOP_C_DEBUG];
   wire logic       master_m = ctrl_q[DOP_C_MASTER];
   wire logic       slv_pol  = ctrl_q[DOP_C_SLV_POL];
   wire logic [7:0] rate     = ctrl_q[DOP_C_RATE_HI:DOP_C_RATE_LO];

   // ==========================================================
   // APB decode
   wire logic setup   = psel_in & ~penable_in;
   wire logic access  = psel_in & penable_in;
   wire logic wr      = access & pwrite_in;
   wire logic hit_ctl = paddr_in == DOP_CTRL_OFS;
   wire logic hit_dbg = paddr_in == DOP_DEBUG_OFS;
   wire logic hit_ist = paddr_in == DOP_IRQ_ST_OFS;
   wire logic hit_msk = paddr_in == DOP_IRQ_MSK_OFS;
   wire logic hit_sta = paddr_in == DOP_STATE_OFS;
   wire logic hit_dsy = paddr_in == DOP_DAISY_OFS;
   wire logic mapped  = hit_ctl | hit_dbg | hit_ist | hit_msk | hit_sta | hit_dsy;

   wire logic [31:0] state_word = {18'h00000, chan_b_gain_word_out, chan_a_gain_word_out,
                                   2'h0, state_q, pend_q, phase_q, conv_en_q};
   wire logic [31:0] rd_mux =
      hit_ctl ? {16'h0000, ctrl_q} :
      hit_dbg ? {12'h000, dbg_q} :
      hit_ist ? {30'h00000000, irq_st_q} :
      hit_msk ? {30'h00000000, irq_msk_q} :
      hit_sta ? state_word :
      hit_dsy ? {cap_b_q, cap_a_q} : 32'h00000000;

   // Zero wait states; read data is captured in the setup cycle
   assign pready_out  = 1'b1;
   assign pslverr_out = access & ~mapped;
   assign prdata_out  = rdata_q;

   always_ff @(posedge clk_in) begin
      if (core_rst) begin
         rdata_q <= 32'h00000000;
      end else if (setup) begin
         rdata_q <= rd_mux;
      end
   end

   // Software writes
   always_ff @(posedge clk_in) begin
      if (core_rst) begin
         ctrl_q    <= DOP_CTRL_RST;
         dbg_q     <= DOP_DEBUG_RST;
         irq_msk_q <= DOP_IRQ_RST;
      end else if (wr) begin
         if (hit_ctl) ctrl_q <= pwdata_in[15:0];
         if (hit_dbg) dbg_q <= pwdata_in[19:0];
         if (hit_msk) irq_msk_q <= pwdata_in[1:0];
      end
   end

   // ==========================================================
   // Interrupts: new events win over a write-one clear
   wire logic [1:0] irq_ev  = {dsy_done_q, sample_in.valid};
   wire logic [1:0] irq_clr = (wr & hit_ist) ? pwdata_in[1:0] : 2'h0;

   always_ff @(posedge clk_in) begin
      if (core_rst) begin
         irq_st_q <= DOP_IRQ_RST;
      end else begin
         irq_st_q <= (irq_st_q & ~irq_clr) | irq_ev;
      end
   end

   assign irq_out = |(irq_st_q & irq_msk_q);

   // ==========================================================
   // Converter power control
   always_ff @(posedge clk_in) begin
      if (core_rst) begin
         conv_en_q <= DOP_CONV_RST;
      end else begin
         conv_en_q <= {2{~pdn_s}};
      end
   end

   assign converter_enable_out = conv_en_q;

   // ==========================================================
   // Bit clock divider: half period is rate cycles
   wire logic rate_zero = rate == 8'h00;
   wire logic div_hit   = div_cnt_q == 8'(rate - 8'h01);
   // Launch marks the edge on which serial bits change
   wire logic launch    = rate_zero | (div_hit & ~phase_q);

   always_ff @(posedge clk_in) begin
      if (core_rst | rate_zero) begin
         div_cnt_q <= 8'h00;
         phase_q   <= 1'b0;
      end else if (div_hit) begin
         div_cnt_q <= 8'h00;
         phase_q   <= ~phase_q;
      end else begin
         div_cnt_q <= div_cnt_q + 8'h01;
      end
   end

   // Rate zero passes the input clock through, duty cycle and all;
   // this puts a clock on a data path, accepted for that mode only
   wire logic sck_raw = rate_zero ? clk_in : phase_q;

   // ==========================================================
   // Sample capture
   always_ff @(posedge clk_in) begin
      if (ser_rst) begin
         samp_q <= '0;
         rdy_q  <= 1'b0;
      end else begin
         rdy_q <= sample_in.valid;
         if (sample_in.valid) samp_q <= sample_in;
      end
   end

   // ==========================================================
   // Serialiser: 32 bits per channel, I word then Q word
   always_ff @(posedge clk_in) begin
      if (ser_rst) begin
         state_q   <= DOP_IDLE;
         pend_q    <= 1'b0;
         bit_cnt_q <= 5'h00;
         sh_a_q    <= 32'h00000000;
         sh_b_q    <= 32'h00000000;
      end else begin
         if (sample_in.valid) pend_q <= 1'b1;
         if (launch) begin
            case (state_q)
               DOP_IDLE: begin
                  if (pend_q) begin
                     sh_a_q    <= {samp_q.a_i, samp_q.a_q};
                     sh_b_q    <= {samp_q.b_i, samp_q.b_q};
                     bit_cnt_q <= 5'h00;
                     state_q   <= DOP_SHIFT;
                     if (!sample_in.valid) pend_q <= 1'b0;
                  end
               end
               DOP_SHIFT: begin
                  if (bit_cnt_q == DOP_FRAME_LAST) begin
                     state_q <= DOP_IDLE;
                  end else begin
                     sh_a_q    <= {sh_a_q[30:0], 1'b0};
                     sh_b_q    <= {sh_b_q[30:0], 1'b0};
                     bit_cnt_q <= bit_cnt_q + 5'h01;
                  end
               end
               default: begin
                  state_q <= DOP_IDLE;
               end
            endcase
         end
      end
   end

   // Frame at word start, or only at pair start when packed
   wire logic shifting = state_q == DOP_SHIFT;
   wire logic frame    = shifting & ((bit_cnt_q == 5'h00) |
                                     (~packed_m & (bit_cnt_q == DOP_HALF_WORD)));

   // ==========================================================
   // Serial pin mapping, debug remap
   assign serial_pins_out.chan_a_serial_data = debug_m ? dbg_q[1] : shifting & sh_a_q[31];
   assign serial_pins_out.chan_b_serial_data = debug_m ? dbg_q[0] : shifting & sh_b_q[31];
   assign serial_pins_out.serial_frame_pulse = debug_m ? dbg_q[2] : frame ^ frm_pol;
   assign serial_pins_out.bit_clock          = sck_raw ^ bck_pol;
   assign serial_oe_out                      = ser_en;

   // Ready flag never depends on the serial enable
   assign ready_flag_out = debug_m ? dbg_q[3] : rdy_q ^ rdy_pol;

   // ==========================================================
   // Daisy-chain capture from the select pins
   wire logic slv_frame = sel_s[2] ^ frm_pol;
   wire logic cap_edge  = master_m & (slv_pol ? (sck_s & ~sck_prev_q)
                                              : (~sck_s & sck_prev_q));
   wire logic [15:0] dsy_a_nx = {dsy_a_q[14:0], sel_s[0]};
   wire logic [15:0] dsy_b_nx = {dsy_b_q[14:0], sel_s[1]};

   always_ff @(posedge clk_in) begin
      if (core_rst) begin
         sck_prev_q <= 1'b0;
      end else begin
         sck_prev_q <= sck_s;
      end
   end

   // Only the first 16 bits after a slave frame are kept; a packed
   // slave's second word is dropped
   always_ff @(posedge clk_in) begin
      if (core_rst) begin
         dsy_cnt_q  <= 5'h00;
         dsy_a_q    <= 16'h0000;
         dsy_b_q    <= 16'h0000;
         cap_a_q    <= 16'h0000;
         cap_b_q    <= 16'h0000;
         dsy_done_q <= 1'b0;
      end else begin
         dsy_done_q <= 1'b0;
         if (cap_edge) begin
            dsy_a_q <= dsy_a_nx;
            dsy_b_q <= dsy_b_nx;
            if (slv_frame) begin
               dsy_cnt_q <= 5'h01;
            end else if (dsy_cnt_q == DOP_DAISY_LAST) begin
               dsy_cnt_q  <= 5'h00;
               cap_a_q    <= dsy_a_nx;
               cap_b_q    <= dsy_b_nx;
               dsy_done_q <= 1'b1;
            end else if (dsy_cnt_q != 5'h00) begin
               dsy_cnt_q <= dsy_cnt_q + 5'h01;
            end
         end
      end
   end

   // ==========================================================
   // Parallel port: eight selectable words
   logic [7:0][15:0] pwords;
   assign pwords = {cap_b_q, cap_a_q, {14'h0000, irq_st_q},
                    {10'h000, chan_a_gain_word_out, chan_b_gain_word_out},
                    samp_q.b_q, samp_q.b_i, samp_q.a_q, samp_q.a_i};

   always_ff @(posedge clk_in) begin
      if (core_rst) begin
         par_q <= 16'h0000;
      end else begin
         par_q <= debug_m ? dbg_q[19:4] : pwords[sel_s];
      end
   end

   assign parallel_word_bus_out = par_q;
   assign parallel_oe_out       = debug_m | ~pen_n_s;

   // ==========================================================
   // Gain ports, one per channel
   logic [1:0]      gain_upd;
   logic [1:0][2:0] gain_in;
   logic [1:0][2:0] gain_out;
   logic [1:0]      gain_n;
   assign gain_upd = {agc_in.b_update, agc_in.a_update};
   assign gain_in  = {agc_in.b_gain, agc_in.a_gain};

   for (genvar ch = 0; ch < 2; ch++) begin : g_gain
      dop_gain_latch u_gain (
         .clk_in           (clk_in),
         .hold_in          (ser_rst),
         .update_in        (gain_upd[ch]),
         .gain_in          (gain_in[ch]),
         .gain_word_out    (gain_out[ch]),
         .gain_latch_n_out (gain_n[ch])
      );
   end

   assign chan_a_gain_word_out    = gain_out[0];
   assign chan_b_gain_word_out    = gain_out[1];
   assign chan_a_gain_latch_n_out = gain_n[0];
   assign chan_b_gain_latch_n_out = gain_n[1];

endmodule

// File: tb/dop_dsp_model.sv
/*
 Serial receiver standing for the capture logic at the far side.
 Assumes bit clock polarity 0; counts bits from each frame pulse.
*/
`timescale 1ns/100ps
module dop_dsp_model
   import dop_pkg::*;
(
   input  wire dop_serial_type pins_in,
   input  wire logic           oe_in,
   output logic      [31:0]    word_out,
   output logic      [15:0]    half_out
);
   // ==========================================================
   // Capture on the falling bit clock, MSB first
   logic [31:0] sh  = 32'h0;
   int          cnt = 0;
   initial begin
      word_out = 32'h0;
      half_out = 16'h0;
   end
   always @(negedge pins_in.bit_clock) begin
      if (oe_in) begin
         sh = {sh[30:0], pins_in.chan_a_serial_data};
         cnt = pins_in.serial_frame_pulse ? 1 : cnt + 1;
         if (cnt == 16) half_out = sh[15:0];
         if (cnt == 32) word_out = sh;
      end
   end
endmodule

// File: tb/dop_props.sv
/*
 Pin timing checker for the output port.
 Assumes bind into dop_top and one clock domain.
*/
`timescale 1ns/100ps
module dop_props
   import dop_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire dop_agc_type agc_in,
   input  wire logic        converter_power_down_in,
   input  wire logic        master_reset_n_in,
   input  wire logic        sync_n_in,
   input  wire logic        parallel_drive_enable_n_in,
   input  wire logic [1:0]  converter_enable_out,
   input  wire logic        serial_oe_out,
   input  wire logic        parallel_oe_out,
   input  wire logic [2:0]  chan_a_gain_word_out,
   input  wire logic        chan_a_gain_latch_n_out,
   input  wire logic        chan_b_gain_latch_n_out
);
   // ==========================================================
   // Quiet history, so pin flushes do not look like faults
   logic [6:0] ok_q;
   always_ff @(posedge clk_in) begin
      ok_q <= rst_in ? 7'h00 : {ok_q[5:0], master_reset_n_in & sync_n_in};
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // ==========================================================
   // Properties
   pd_follow_a: assert property (&ok_q |-> converter_enable_out == {2{!$past(converter_power_down_in, 3)}})
      else $error("converter enable wrong");
   mr_strobe_a: assert property (!master_reset_n_in [*5] |-> !chan_a_gain_latch_n_out && !chan_b_gain_latch_n_out)
      else $error("strobe high in reset");
   sync_strobe_a: assert property (!sync_n_in [*5] |-> !chan_a_gain_latch_n_out && !chan_b_gain_latch_n_out)
      else $error("strobe high in sync");
   ser_off_a: assert property ($fell(rst_in) |-> !serial_oe_out)
      else $error("serial driven after reset");
   par_drive_a: assert property (!parallel_drive_enable_n_in [*3] |-> parallel_oe_out)
      else $error("parallel bus not driven");
   gain_word_a: assert property (agc_in.a_update && &ok_q |=> chan_a_gain_word_out == $past(agc_in.a_gain))
      else $error("gain word wrong");
   gain_latch_a: assert property (agc_in.b_update && &ok_q |-> ##[1:2] !chan_b_gain_latch_n_out)
      else $error("no gain strobe");
   latch_end_a: assert property ($fell(chan_a_gain_latch_n_out) && &ok_q |-> ##[1:3] chan_a_gain_latch_n_out)
      else $error("gain strobe stuck");
endmodule
bind dop_top dop_props u_props (.clk_in(clk_in), .rst_in(rst_in), .agc_in(agc_in),
   .converter_power_down_in(converter_power_down_in), .master_reset_n_in(master_reset_n_in),
   .sync_n_in(sync_n_in), .parallel_drive_enable_n_in(parallel_drive_enable_n_in),
   .converter_enable_out(converter_enable_out), .serial_oe_out(serial_oe_out),
   .parallel_oe_out(parallel_oe_out), .chan_a_gain_word_out(chan_a_gain_word_out),
   .chan_a_gain_latch_n_out(chan_a_gain_latch_n_out), .chan_b_gain_latch_n_out(chan_b_gain_latch_n_out));

// File: tb/dop_top_bench.sv
/*
 Self-checking bench for dop_top with an APB master and serial receiver.
 Assumes the 25 MHz clock and pins driven at rising edges.
*/
`timescale 1ns/100ps
module dop_top_bench
   import dop_pkg::*;
;
   typedef struct packed {logic [2:0] sel; logic [15:0] exp;} dop_row_type;
   logic           clk_in = 0, rst_in = 1, psel = 0, pen = 0, pwr = 0, serr;
   logic           pdn = 0, mrn = 1, sy_n = 1, lck = 0, pen_n = 1, pready, pslverr;
   logic [7:0]     paddr = 8'h00;
   logic [31:0]    pwdata = 32'h0, rd, prdata, mword;
   logic [2:0]     sel = 3'h0, ga, gb;
   dop_sample_type smp = '{1'b0, 16'h8001, 16'h7FFE, 16'h1234, 16'hC3A5};
   dop_agc_type    agc = '0;
   dop_serial_type ser;
   logic [15:0]    pbus, mhalf;
   logic [1:0]     conv;
   logic           soe, poe, rdy, la_n, lb_n, irq;
   int             error_cnt = 0, total_checks = 0, cyc = 0;
   dop_row_type    rows [8] = '{'{0, 16'h8001}, '{1, 16'h7FFE}, '{2, 16'h1234}, '{3, 16'hC3A5},
                               '{4, 16'h002B}, '{5, 16'h0003}, '{6, 16'h5A0F}, '{7, 16'hF0A5}};
   dop_top DUT (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
      .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .sample_in(smp), .agc_in(agc), .converter_power_down_in(pdn),
      .master_reset_n_in(mrn), .sync_n_in(sy_n), .daisy_bit_clock_in(lck),
      .parallel_word_select_in(sel), .parallel_drive_enable_n_in(pen_n),
      .converter_enable_out(conv), .serial_pins_out(ser), .serial_oe_out(soe),
      .parallel_word_bus_out(pbus), .parallel_oe_out(poe), .ready_flag_out(rdy),
      .chan_a_gain_word_out(ga), .chan_b_gain_word_out(gb), .chan_a_gain_latch_n_out(la_n),
      .chan_b_gain_latch_n_out(lb_n), .irq_out(irq));
   dop_dsp_model u_dsp (.pins_in(ser), .oe_in(soe), .word_out(mword), .half_out(mhalf));
   // ==========================================================
   // Clock and hang guard; a full run needs about 650 cycles
   initial forever #20 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         final_report;
      end
   end
   // ==========================================================
   // Shared tasks
   task automatic final_report;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   // Setup cycle, then access held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      pen <= 1'b1;
      do @(posedge clk_in); while (pready !== 1'b1);
      rd = prdata;
      serr = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic send_smp;
      smp.valid <= 1'b1;
      tick(1);
      smp.valid <= 1'b0;
      #1 chk("ready", rdy, 1);
      tick(200);
   endtask
   // Slave word over the link pins; clock stands low outside the frame
   task automatic daisy(input logic [15:0] a, input logic [15:0] b);
      for (int i = 15; i >= 0; i--) begin
         sel <= {i == 15, b[i], a[i]};
         lck <= 1'b1;
         tick(4);
         lck <= 1'b0;
         tick(4);
      end
      sel <= 3'h0;
      tick(6);
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      tick(6);
      rst_in <= 1'b0;
      #1 chk("serial oe", soe, 0);
      apb(0, DOP_CTRL_OFS, 0);
      chk("ctrl", rd, DOP_CTRL_RST);
      apb(0, 8'h40, 0);
      chk("slverr", serr, 1);
      agc <= '{1'b1, 1'b1, 3'h5, 3'h3};
      tick(1);
      agc <= '{1'b0, 1'b0, 3'h5, 3'h3};
      tick(2);
      chk("gain b", gb, 3'h3);
      apb(1, DOP_CTRL_OFS, 32'h0205);
      send_smp;
      chk("packed word", mword, 32'h80017FFE);
      apb(1, DOP_CTRL_OFS, 32'h0201);
      send_smp;
      chk("unpacked half", mhalf, 16'h7FFE);
      apb(1, DOP_CTRL_OFS, 32'h0001);
      #1 chk("sck high", ser.bit_clock, 1);
      @(negedge clk_in);
      #1 chk("sck low", ser.bit_clock, 0);
      apb(1, DOP_CTRL_OFS, 32'h0040);
      daisy(16'h5A0F, 16'hF0A5);
      apb(0, DOP_DAISY_OFS, 0);
      chk("daisy", rd, 32'hF0A55A0F);
      apb(1, DOP_CTRL_OFS, 0);
      pen_n <= 1'b0;
      foreach (rows[i]) begin
         sel <= rows[i].sel;
         tick(4);
         chk("word", pbus, rows[i].exp);
      end
      pen_n <= 1'b1;
      tick(4);
      chk("bus off", poe, 0);
      chk("irq masked", irq, 0);
      apb(1, DOP_IRQ_MSK_OFS, 1);
      tick(1);
      chk("irq", irq, 1);
      apb(1, DOP_IRQ_ST_OFS, 3);
      tick(1);
      chk("irq clear", irq, 0);
      apb(1, DOP_DEBUG_OFS, 32'hABCD9);
      apb(1, DOP_CTRL_OFS, 32'h0021);
      tick(4);
      chk("debug bus", pbus, 16'hABCD);
      chk("debug oe", poe, 1);
      chk("debug ser", {ser.chan_a_serial_data, ser.chan_b_serial_data, ser.serial_frame_pulse}, 3'b010);
      chk("debug rdy", rdy, 1);
      pdn <= 1'b1;
      tick(5);
      chk("conv off", conv, 2'b00);
      pdn <= 1'b0;
      tick(5);
      chk("conv on", conv, 2'b11);
      sy_n <= 1'b0;
      tick(6);
      chk("sync strobe", la_n, 0);
      sy_n <= 1'b1;
      mrn <= 1'b0;
      tick(6);
      chk("mr strobe", lb_n, 0);
      mrn <= 1'b1;
      tick(5);
      apb(0, DOP_CTRL_OFS, 0);
      chk("ctrl after mr", rd, 0);
      final_report;
   end
endmodule
